//--- logic/idc_pkg.sv
/*
 * Constants, frame layout and types for the isolated driver
 * configuration port.
 * Assumes a 10 MHz ref_clk far faster than the serial clock.
 */
// Behaviour
// - access only while select low and fault pin pulled low externally
// - transfers whose clock count is not a multiple of 24 are ignored
// - bits shifted in pass onward on the data output for chaining
// - gate output forced off while select and fault pin are both low
// - gate output works normally again once select returns high
// - clock idles low, data captured on second edge of each bit
// - two address bits in the frame pick the register
// - 24 data bits per frame, most significant bit first
// - direction bit zero reads, one writes
// - written values go to the nonvolatile memory on the far side
// - address 00 trim, 01 protection settings, 10 memory control
// - trim bits 23:18 offset and 17:12 gain of input b
// - trim bits 11:6 offset and 5:0 gain of input a
// - control bits 5:2 memory errors, bit 1 busy, bit 0 simulated trim
// - settings bit 0 picks report rate, 0 slow, 1 fast
`default_nettype none
package idc_pkg;
  localparam int WORD_W = 24;
  localparam int FRAME_W = 48;
  localparam int MBZ_W = 21;
  localparam logic [4:0] BIT_LAST = 5'h17;
  localparam logic [4:0] BIT_FIRST = 5'h00;
  localparam logic [1:0] WORDS_MIN = 2'h2;
  localparam logic [1:0] ADDR_TRIM = 2'h0;
  localparam logic [1:0] ADDR_PROT = 2'h1;
  localparam logic [1:0] ADDR_CTRL = 2'h2;
  localparam int RATE_BIT = 0;
  localparam int SIM_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int ECC_LSB = 2;
  localparam logic [23:0] TRIM_RST = 24'h000000;
  localparam logic [23:0] PROT_RST = 24'h000000;
  localparam logic [17:0] CTRL_PAD = 18'h00000;
  localparam logic [20:0] MBZ_VAL = 21'h000000;

  // header word: direction, address, then must-be-zero filler
  typedef struct packed {
    logic dir;
    logic [1:0] addr;
    logic [MBZ_W-1:0] must_zero_bits;
  } idc_hdr_t;

  typedef struct packed {
    logic [5:0] b_offset;
    logic [5:0] b_gain;
    logic [5:0] a_offset;
    logic [5:0] a_gain;
  } idc_trim_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
    logic uvlo;
  } idc_pins_t;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_PROG} idc_state_t;
endpackage
`default_nettype wire

//--- logic/idc_spi_cfg.sv
/*
 * Serial configuration port of the isolated gate driver: pin
 * synchronisers, 48-bit frame shifter, register shadows, memory
 * write strobe and gate blanking.
 * Assumes nvm_done, ecc_err, gate_cmd and uv_fault_det come from
 * logic on ref_clk; the serial pins are asynchronous.
 */
`default_nettype none
module idc_spi_cfg
  import idc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic undervoltage_fault_pin_i,
  input wire logic uv_fault_det,
  input wire logic gate_cmd,
  input wire logic nvm_done,
  input wire logic [3:0] ecc_err,
  output logic miso,
  output logic miso_oe_n,
  output logic undervoltage_fault_pin_o,
  output logic undervoltage_fault_pin_oe_n,
  output logic gate_out,
  output logic nvm_wr_stb,
  output logic [1:0] nvm_wr_addr,
  output logic [23:0] nvm_wr_data,
  output idc_trim_t trim,
  output logic [23:0] prot,
  output logic simulated_trim_request,
  output logic report_rate
);

  idc_pins_t s1_q, s2_q;
  logic sclk_prev_q;
  idc_state_t st_q, st_d;
  logic [FRAME_W-1:0] sr_q, sr_d;
  logic [4:0] bit_q, bit_d;
  logic [1:0] wrd_q, wrd_d;
  logic miso_q, miso_d, moe_n_q, moe_n_d;
  idc_trim_t trim_q, trim_d;
  logic [23:0] prot_q, prot_d;
  logic sim_q, sim_d;
  logic stb_q, stb_d;
  logic [1:0] waddr_q, waddr_d;
  logic [23:0] wdata_q, wdata_d;
  logic gate_q, gate_d, uoe_n_q, uoe_n_d, rate_q, rate_d;
  logic sclk_rise, sclk_fall, act, blank, busy, sr_msb;
  idc_hdr_t hdr, hdr_in;
  logic [FRAME_W-1:0] sr_sh;

  // read-back mux; control word is mostly live status
  function automatic logic [23:0] rd_mux(input logic [1:0] a,
                                         input logic bz);
    logic [23:0] v;
    v = 24'h000000;
    case (a)
      ADDR_TRIM: v = trim_q;
      ADDR_PROT: v = prot_q;
      ADDR_CTRL: v = {CTRL_PAD, ecc_err, bz, sim_q};
      default: v = 24'h000000;
    endcase
    return v;
  endfunction

  // two-flop synchronisers on every pin from the host side
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0, uvlo: 1'b1};
      s2_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0, uvlo: 1'b1};
      sclk_prev_q <= 1'b0;
    end else begin
      s1_q <= '{cs_n: cs_n, sclk: sclk, mosi: mosi, uvlo: undervoltage_fault_pin_i};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q.sclk;
    end
  end

  // edges are seen from the second stage only
  assign sclk_rise = s2_q.sclk & ~sclk_prev_q;
  assign sclk_fall = ~s2_q.sclk & sclk_prev_q;
  // pin low while we are not pulling it means the host holds it
  assign act = ~s2_q.cs_n & ~s2_q.uvlo & uoe_n_q;
  assign blank = ~s2_q.cs_n & ~s2_q.uvlo;
  assign busy = (st_q == ST_PROG);
  assign sr_msb = sr_q[FRAME_W-1];
  assign hdr = idc_hdr_t'(sr_q[FRAME_W-1:WORD_W]);
  assign sr_sh = {sr_q[FRAME_W-2:0], s2_q.mosi};
  assign hdr_in = idc_hdr_t'(sr_sh[WORD_W-1:0]);

  // frame sequencer, shifter and register shadows
  always_comb begin
    st_d = st_q;
    sr_d = sr_q;
    bit_d = bit_q;
    wrd_d = wrd_q;
    miso_d = miso_q;
    moe_n_d = 1'b1;
    trim_d = trim_q;
    prot_d = prot_q;
    sim_d = sim_q;
    stb_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    case (st_q)
      ST_IDLE: begin
        if (act) begin
          st_d = ST_SHIFT;
          bit_d = BIT_FIRST;
          wrd_d = 2'h0;
          miso_d = sr_msb;
          moe_n_d = 1'b0;
        end
      end
      ST_SHIFT: begin
        if (!act) begin
          st_d = ST_IDLE;
          // only whole words count, and the last two are ours
          if (bit_q == BIT_FIRST && wrd_q == WORDS_MIN &&
              hdr.must_zero_bits == MBZ_VAL && hdr.addr != 2'h3 &&
              hdr.dir) begin
            waddr_d = hdr.addr;
            wdata_d = sr_q[WORD_W-1:0];
            stb_d = 1'b1;
            st_d = ST_PROG;
            case (hdr.addr)
              ADDR_TRIM: trim_d = idc_trim_t'(sr_q[WORD_W-1:0]);
              ADDR_PROT: prot_d = sr_q[WORD_W-1:0];
              default: sim_d = sr_q[SIM_BIT];
            endcase
          end
        end else begin
          moe_n_d = 1'b0;
          // change on the rising edge so the host samples on falling
          if (sclk_rise) begin
            miso_d = sr_msb;
          end
          if (sclk_fall) begin
            sr_d = sr_sh;
            if (bit_q == BIT_LAST) begin
              bit_d = BIT_FIRST;
              if (wrd_q != WORDS_MIN) begin
                wrd_d = wrd_q + 2'h1;
              end
              // read answer rides out in the following word
              if (wrd_q == 2'h0 && !hdr_in.dir) begin
                sr_d[FRAME_W-1:WORD_W] = rd_mux(hdr_in.addr, busy);
              end
            end else begin
              bit_d = bit_q + 5'h01;
            end
          end
        end
      end
      ST_PROG: begin
        // further accesses wait until the far side has stored it
        if (nvm_done) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // gate blanking and fault pin drive
  always_comb begin
    gate_d = gate_cmd & ~blank;
    uoe_n_d = ~uv_fault_det;
    rate_d = prot_q[RATE_BIT];
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      sr_q <= '0;
      bit_q <= BIT_FIRST;
      wrd_q <= 2'h0;
      miso_q <= 1'b0;
      moe_n_q <= 1'b1;
      trim_q <= TRIM_RST;
      prot_q <= PROT_RST;
      sim_q <= 1'b0;
      stb_q <= 1'b0;
      waddr_q <= 2'h0;
      wdata_q <= 24'h000000;
      gate_q <= 1'b0;
      uoe_n_q <= 1'b1;
      rate_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sr_q <= sr_d;
      bit_q <= bit_d;
      wrd_q <= wrd_d;
      miso_q <= miso_d;
      moe_n_q <= moe_n_d;
      trim_q <= trim_d;
      prot_q <= prot_d;
      sim_q <= sim_d;
      stb_q <= stb_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      gate_q <= gate_d;
      uoe_n_q <= uoe_n_d;
      rate_q <= rate_d;
    end
  end

  // every output straight from a flop, except undervoltage_fault_pin_o, which is tied low
  assign miso = miso_q;
  assign miso_oe_n = moe_n_q;
  assign undervoltage_fault_pin_o = 1'b0;
  assign undervoltage_fault_pin_oe_n = uoe_n_q;
  assign gate_out = gate_q;
  assign nvm_wr_stb = stb_q;
  assign nvm_wr_addr = waddr_q;
  assign nvm_wr_data = wdata_q;
  assign trim = trim_q;
  assign prot = prot_q;
  assign simulated_trim_request = sim_q;
  assign report_rate = rate_q;

  // checks on the design's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_GATE_BLANK: assert property (blank |=> !gate_q)
    else $error("gate not blanked during access");
  AST_GATE_BACK: assert property (
    ($rose(s2_q.cs_n) && gate_cmd) |=> gate_q)
    else $error("gate not restored after select high");
  AST_IDLE_GUARD: assert property (
    (st_q == ST_IDLE && (s2_q.cs_n || s2_q.uvlo)) |=> st_q != ST_SHIFT)
    else $error("access started while port inactive");
  AST_ODD_COUNT: assert property (
    (st_q == ST_SHIFT && !act && bit_q != BIT_FIRST) |=> !stb_q)
    else $error("partial word transfer committed");
  AST_TRIM_WRITE: assert property (
    (st_q == ST_SHIFT && !act && bit_q == BIT_FIRST &&
     wrd_q == WORDS_MIN && hdr.dir && hdr.must_zero_bits == MBZ_VAL &&
     hdr.addr == ADDR_TRIM)
    |=> stb_q && trim_q == wdata_q && waddr_q == ADDR_TRIM)
    else $error("trim write not committed");
  AST_MISO_EDGE: assert property (
    (st_q == ST_SHIFT && act && sclk_rise) |=> miso_q == $past(sr_msb))
    else $error("data out not updated on rising edge");
  AST_SHIFT_IN: assert property (
    (st_q == ST_SHIFT && act && sclk_fall)
    |=> sr_q[0] == $past(s2_q.mosi) && bit_q != $past(bit_q))
    else $error("data in not captured on falling edge");
  AST_BUSY_FLAG: assert property (
    stb_q |-> busy ##1 (busy || $past(nvm_done)))
    else $error("busy flag missing during programming");
  AST_RATE_SEL: assert property (
    $changed(prot_q) |=> rate_q == $past(prot_q[RATE_BIT]))
    else $error("report rate not following settings");

endmodule
`default_nettype wire

//--- verif/idc_host_model.sv
/*
 Serial host model: select, clock and data, mode CPOL 0 CPHA 1.
 Assumes ref_clk of 100 ns paces it; one bit takes 800 ns.
*/
`default_nettype none
module idc_host_model (
  input wire logic ref_clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  output logic pull
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: clock low, select high, fault pin left alone
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    pull = 1'b0;
  end
  // one select period of n clocks, msb first; miso read late in the bit
  task automatic xfer(input int n, input logic [71:0] b, input logic pl,
                      output logic [71:0] got);
    got = '0;
    pull <= pl;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b1;
      mosi <= b[i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
      got = {got[70:0], miso};
    end
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    mosi <= ~mosi; // released line must not keep its last value
    repeat (8) @(posedge ref_clk);
    pull <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
/*
 Self-checking bench for the configuration port.
 Assumes idc_pkg, idc_spi_cfg and idc_host_model are compiled first.
*/
`default_nettype none
module testbench import idc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, arst_n, gate_cmd, uv_det, nvm_done, uvlo_i, stb, rate;
  logic sclk, cs_n, mosi, pull, miso, oe_n, uvlo_oe_n, gate_out, sim;
  logic [3:0] ecc, dly;
  logic [1:0] wa, w_addr;
  logic [23:0] wd, prot, w_data;
  logic [71:0] got;
  idc_trim_t trim;
  int error_cnt, samples_checked, stb_cnt, gate_bad, lo_cnt;
  // open-drain fault pin with pull-up
  assign uvlo_i = ~(pull | ~uvlo_oe_n);
  idc_host_model host_u (.ref_clk(ref_clk), .miso(miso), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .pull(pull));
  idc_spi_cfg dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .undervoltage_fault_pin_i(uvlo_i), .uv_fault_det(uv_det),
    .gate_cmd(gate_cmd), .nvm_done(nvm_done), .ecc_err(ecc), .miso(miso),
    .miso_oe_n(oe_n), .undervoltage_fault_pin_o(), .undervoltage_fault_pin_oe_n(uvlo_oe_n),
    .gate_out(gate_out), .nvm_wr_stb(stb), .nvm_wr_addr(wa),
    .nvm_wr_data(wd), .trim(trim), .prot(prot), .simulated_trim_request(sim),
    .report_rate(rate));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // memory side: answers each strobe a few cycles later
  always @(posedge ref_clk) begin
    nvm_done <= dly[3];
    dly <= {dly[2:0], stb};
    if (stb === 1'b1) begin
      stb_cnt <= stb_cnt + 1;
      w_addr <= wa;
      w_data <= wd;
    end
  end
  // gate must be off while the pin is low once select has been low a while
  always @(negedge ref_clk) begin
    lo_cnt <= cs_n ? 0 : lo_cnt + 1;
    if (lo_cnt > 5 && !uvlo_i && gate_out !== 1'b0) gate_bad++;
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [23:0] hdr(input logic d, input logic [1:0] a);
    return {d, a, MBZ_VAL};
  endfunction
  // frame plus 16 cycles for strobe and memory answer
  task automatic xw(input int n, input logic [71:0] b, input logic pl);
    host_u.xfer(n, b, pl, got);
    repeat (16) @(posedge ref_clk);
  endtask
  task automatic t_write();
    int s;
    s = stb_cnt;
    gate_bad = 0;
    xw(48, {24'h0, hdr(1'b1, ADDR_TRIM), 6'h21, 6'h0C, 6'h33, 6'h1E}, 1);
    chk(24'(stb_cnt - s), 24'h1);
    chk(w_addr, ADDR_TRIM);
    chk(w_data, 24'h84CCDE);
    chk(trim.b_offset, 6'h21);
    chk(trim.b_gain, 6'h0C);
    chk(trim.a_offset, 6'h33);
    chk(trim.a_gain, 6'h1E);
    chk(24'(gate_bad), 24'h0);
    chk(gate_out, 1'b1);
    $display("test write finished");
  endtask
  task automatic t_prot();
    int s;
    xw(48, {24'h0, hdr(1'b1, ADDR_PROT), 24'h5A0C31}, 1);
    chk(rate, 1'b1);
    xw(48, {24'h0, hdr(1'b1, ADDR_PROT), 24'h5A0C30}, 1);
    chk(prot, 24'h5A0C30);
    chk(rate, 1'b0);
    s = stb_cnt;
    xw(48, {24'h0, hdr(1'b0, ADDR_PROT), 24'h0}, 1);
    chk(got[23:0], 24'h5A0C30);
    chk(24'(stb_cnt - s), 24'h0);
    $display("test settings finished");
  endtask
  task automatic t_refuse();
    int s;
    s = stb_cnt;
    xw(47, {24'h0, hdr(1'b1, ADDR_TRIM), 24'h0}, 1);
    xw(48, {24'h0, hdr(1'b1, ADDR_TRIM), 24'h0}, 0);
    xw(48, {24'h0, hdr(1'b1, 2'h3), 24'h0}, 1);
    xw(48, {24'h0, 1'b1, ADDR_TRIM, 21'h000001, 24'h0}, 1);
    chk(trim, 24'h84CCDE);
    chk(24'(stb_cnt - s), 24'h0);
    $display("test refusals finished");
  endtask
  task automatic t_ctrl();
    ecc <= 4'h9;
    xw(48, {24'h0, hdr(1'b1, ADDR_CTRL), 24'h000001}, 1);
    chk(sim, 1'b1);
    xw(48, {24'h0, hdr(1'b0, ADDR_CTRL), 24'h0}, 1);
    chk(got[23:0], {CTRL_PAD, 4'h9, 1'b0, 1'b1});
    $display("test control finished");
  endtask
  task automatic t_chain();
    xw(72, {24'h3C5A69, hdr(1'b1, ADDR_PROT), 24'h0}, 1);
    chk(got[23:0], 24'h3C5A69);
    chk(prot, 24'h0);
    $display("test chain finished");
  endtask
  // watchdog: the whole run needs well under 30000 cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
  // reset, then the scenarios in turn
  initial begin
    arst_n = 1'b0;
    gate_cmd = 1'b1;
    uv_det = 1'b0;
    nvm_done = 1'b0;
    ecc = 4'h0;
    dly = 4'h0;
    repeat (10) @(posedge ref_clk);
    chk({oe_n, uvlo_oe_n, gate_out, stb}, 4'hC);
    chk(trim, TRIM_RST);
    chk(prot, PROT_RST);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_write();
    t_prot();
    t_refuse();
    t_ctrl();
    t_chain();
    report_and_stop();
  end
endmodule
`default_nettype wire
